// ===== rtl/sswo_lane_mem.sv
`timescale 1ns/1ps
`default_nettype none
// one byte lane with its parity bit; untouched unless its enable is set
module sswo_lane_mem
   import sswo_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 wrEn,
   input  wire logic [ADDR_BITS-1:0] addr,
   input  wire logic [LANE_BITS-1:0] wrData,
   output logic      [LANE_BITS-1:0] rdData
);
   logic [LANE_BITS-1:0] store [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         store[addr] <= wrData;
      end
   end

   assign rdData = store[addr];
endmodule
`default_nettype wire

// ===== rtl/sswo_pkg.sv
package sswo_pkg;
   localparam int LANES      = 4;
   localparam int LANE_BITS  = 9;
   localparam int WORD_BITS  = LANES * LANE_BITS;
   localparam int ADDR_BITS  = 17;
   localparam int DEPTH      = 131072;
   localparam int PARITY_POS = 8;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   localparam logic [LANES-1:0] LANES_ALL  = 4'hf;
   typedef enum logic [1:0] {
      SSWO_IDLE,
      SSWO_READ,
      SSWO_WRITE
   } sswo_cycle_t;
endpackage

// ===== rtl/sswo_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - write when global low, or byte enable low with any lane low
// - read when global high, no lane selected
// - global write writes all lanes, parity
// - byte write updates only enabled lanes
// - every lane enable combination is valid
// - data drive from cycle type and enable
// - output enable acts without clocking
// - processor strobe begins a read when chip selected
// - output enable masked during writes
// - read drives when enable low, selected
module sswo_top
   import sswo_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 proc_addr_strobe_n,
   input  wire logic                 ctrl_addr_strobe_n,
   input  wire logic                 global_write_n,
   input  wire logic                 byte_write_enable_n,
   input  wire logic                 lane0_write_n,
   input  wire logic                 lane1_write_n,
   input  wire logic                 lane2_write_n,
   input  wire logic                 lane3_write_n,
   input  wire logic                 chipSelect,
   input  wire logic                 outEnable_n,
   input  wire logic [ADDR_BITS-1:0] addr,
   input  wire logic [WORD_BITS-1:0] dataIn,
   output logic      [WORD_BITS-1:0] dataOut,
   output logic      [WORD_BITS-1:0] dataOe,
   output logic                      writeCycle
);
   // synchronisers: all pins but outEnable_n pass two flops before any decode
   logic [1:0]           procS;
   logic [1:0]           ctrlS;
   logic [1:0]           gwS;
   logic [1:0]           bweS;
   logic [1:0]           selS;
   logic [LANES-1:0]     laneS1;
   logic [LANES-1:0]     laneS2;
   logic [ADDR_BITS-1:0] addrS1;
   logic [ADDR_BITS-1:0] addrS2;
   logic [WORD_BITS-1:0] dataS1;
   logic [WORD_BITS-1:0] dataS2;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         procS  <= 2'h3;
         ctrlS  <= 2'h3;
         gwS    <= 2'h3;
         bweS   <= 2'h3;
         selS   <= 2'h0;
         laneS1 <= LANES_ALL;
         laneS2 <= LANES_ALL;
         addrS1 <= '0;
         addrS2 <= '0;
         dataS1 <= '0;
         dataS2 <= '0;
      end else begin
         procS  <= {procS[0], proc_addr_strobe_n};
         ctrlS  <= {ctrlS[0], ctrl_addr_strobe_n};
         gwS    <= {gwS[0], global_write_n};
         bweS   <= {bweS[0], byte_write_enable_n};
         selS   <= {selS[0], chipSelect};
         laneS1 <= {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n};
         laneS2 <= laneS1;
         addrS1 <= addr;
         addrS2 <= addrS1;
         dataS1 <= dataIn;
         dataS2 <= dataS1;
      end
   end

   logic             decWrite;
   logic [LANES-1:0] decMask;

   sswo_write_decode u_decode (
      .procStrobe          (procS[1]),
      .global_write_n      (gwS[1]),
      .byte_write_enable_n (bweS[1]),
      .lane_write_n        (laneS2),
      .isWrite             (decWrite),
      .laneMask            (decMask)
   );

   // a write is honoured only once a cycle was opened by either strobe;
   // the master we just refuse writes with no open cycle
   logic        cycleOpen;
   sswo_cycle_t cycle;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cycleOpen <= 1'b0;
      end else if (!procS[1] || !ctrlS[1]) begin
         cycleOpen <= selS[1];
      end
   end

   logic             doWrite;
   logic [LANES-1:0] wrMask;

   always_comb begin
      doWrite = decWrite && selS[1] && (!ctrlS[1] || (procS[1] && cycleOpen));
      wrMask  = doWrite ? decMask : LANES_NONE;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cycle <= SSWO_IDLE;
      end else begin
         case (1'b1)
            doWrite:                        cycle <= SSWO_WRITE;
            (!procS[1] && selS[1]):         cycle <= SSWO_READ;
            (!ctrlS[1] && selS[1]):         cycle <= SSWO_READ;
            (!procS[1] || !ctrlS[1]):       cycle <= SSWO_IDLE;
            default:                        cycle <= (cycle == SSWO_WRITE) ? SSWO_READ : cycle;
         endcase
      end
   end

   logic [WORD_BITS-1:0] rdWord;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gLane
         sswo_lane_mem u_lane (
            .sys_clk (sys_clk),
            .wrEn    (wrMask[g]),
            .addr    (addrS2),
            .wrData  (dataS2[g*LANE_BITS +: LANE_BITS]),
            .rdData  (rdWord[g*LANE_BITS +: LANE_BITS])
         );
      end
   endgenerate

   // read data registered; flow-through latency is traded for clean pins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dataOut <= '0;
      end else if (cycle == SSWO_READ || decWrite == 1'b0) begin
         dataOut <= rdWord;
      end
   end

   assign writeCycle = (cycle == SSWO_WRITE);

   // output enable is deliberately not synchronised: it gates the drive
   // combinationally, and a write masks it so we never fight the bus
   logic driveAll;
   always_comb begin
      driveAll = 1'b0;
      case (cycle)
         SSWO_READ:  driveAll = !outEnable_n;
         SSWO_WRITE: driveAll = 1'b0;
         SSWO_IDLE:  driveAll = 1'b0;
         default:    driveAll = 1'b0;
      endcase
   end

   assign dataOe = {WORD_BITS{driveAll}};
endmodule
`default_nettype wire

// ===== rtl/sswo_write_decode.sv
`timescale 1ns/1ps
`default_nettype none
// combinational write decode from the synchronised strobe/enable pins
module sswo_write_decode
   import sswo_pkg::*;
(
   input  wire logic             procStrobe,
   input  wire logic             global_write_n,
   input  wire logic             byte_write_enable_n,
   input  wire logic [LANES-1:0] lane_write_n,
   output logic                  isWrite,
   output logic [LANES-1:0]      laneMask
);
   logic [LANES-1:0] byteSel;

   always_comb begin
      byteSel = LANES_NONE;
      if (!global_write_n) begin
         byteSel = LANES_ALL;
      end else if (!byte_write_enable_n) begin
         byteSel = ~lane_write_n;
      end
      // processor strobe forces a read whatever the write pins say
      if (!procStrobe) begin
         byteSel = LANES_NONE;
      end
   end

   assign laneMask = byteSel;
   assign isWrite  = |byteSel;
endmodule
`default_nettype wire

// ===== testbench/sswo_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module sswo_bus_master (
   input  wire logic        sys_clk,
   output logic             proc_addr_strobe_n,
   output logic             ctrl_addr_strobe_n,
   output logic             global_write_n,
   output logic             byte_write_enable_n,
   output logic [3:0]       lane_write_n,
   output logic             chipSelect,
   output logic             outEnable_n,
   output logic [16:0]      addr,
   output logic [35:0]      dataIn
);
   initial begin
      {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_enable_n} = 4'hf;
      lane_write_n = 4'hf;
      chipSelect = 1'b0;
      outEnable_n = 1'b1;
      addr = 17'h0;
      dataIn = 36'h0;
   end
   task automatic op(input logic p, c, g, b, input logic [3:0] ln, input logic [35:0] d);
      @(posedge sys_clk);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_enable_n} <= {p, c, g, b};
      lane_write_n <= ln;
      chipSelect <= 1'b1;
      outEnable_n <= !g || (!b && !(&ln));
      dataIn <= d;
      @(posedge sys_clk);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_enable_n} <= 4'hf;
      lane_write_n <= 4'hf;
      outEnable_n <= 1'b0;
      // released bus must not look like the last word
      dataIn <= ~d;
   endtask
   // chip enables only end a cycle at a strobe, so deselect rides on one
   task automatic deselect();
      @(posedge sys_clk);
      chipSelect <= 1'b0;
      ctrl_addr_strobe_n <= 1'b0;
      @(posedge sys_clk);
      ctrl_addr_strobe_n <= 1'b1;
      chipSelect <= 1'b1;
   endtask
   task automatic set_oe(input logic v);
      outEnable_n = v;
   endtask
endmodule
`default_nettype wire

// ===== testbench/sswo_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sswo_properties (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        proc_addr_strobe_n,
   input wire logic        ctrl_addr_strobe_n,
   input wire logic        global_write_n,
   input wire logic        byte_write_enable_n,
   input wire logic        lane0_write_n,
   input wire logic        chipSelect,
   input wire logic        outEnable_n,
   input wire logic [35:0] dataOe,
   input wire logic        writeCycle
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire ctrlGo = !ctrl_addr_strobe_n && proc_addr_strobe_n && chipSelect;
   chk_oe_write: assert property (writeCycle |-> dataOe == '0)
      else $error("data driven in write");
   chk_oe_off: assert property (outEnable_n |-> dataOe == '0)
      else $error("data driven with enable off");
   chk_oe_whole: assert property (dataOe == '0 || dataOe == '1)
      else $error("partial drive");
   chk_global_write: assert property (ctrlGo && !global_write_n |-> ##[2:4] writeCycle)
      else $error("global write missed");
   chk_lane_write: assert property (ctrlGo && !byte_write_enable_n && !lane0_write_n
      |-> ##[2:4] writeCycle) else $error("lane write missed");
   chk_proc_read: assert property (!proc_addr_strobe_n && chipSelect && !global_write_n
      |-> ##[2:4] !writeCycle) else $error("strobe not read");
   chk_plain_read: assert property ((global_write_n && byte_write_enable_n)[*5]
      |=> !writeCycle) else $error("write without enable");
   chk_deselect_idle: assert property (!chipSelect && !ctrl_addr_strobe_n
      |-> ##3 dataOe == '0 && !writeCycle) else $error("active while deselected");
   cover property (writeCycle);
   cover property (dataOe == '1);
   cover property (!proc_addr_strobe_n && !global_write_n);
endmodule
`default_nettype wire

// ===== testbench/sswo_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sync_sram_write_select_oe_tb_top;
   import sswo_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   wire logic proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_enable_n;
   wire logic chipSelect, outEnable_n, writeCycle;
   wire logic [3:0] lane_write_n;
   wire logic [ADDR_BITS-1:0] addr;
   wire logic [WORD_BITS-1:0] dataIn, dataOut, dataOe;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   localparam logic [35:0] BASE = 36'h123456789;
   localparam logic [35:0] NEWD = 36'hedcba9876;
   sswo_bus_master i_sswo_bus_master (.*);
   sswo_top i_sswo_top (.*, .lane0_write_n(lane_write_n[0]), .lane1_write_n(lane_write_n[1]),
      .lane2_write_n(lane_write_n[2]), .lane3_write_n(lane_write_n[3]));
   initial forever #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [35:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic look();
      // cycle type lands two edges after the pins; a write stands one cycle, a read until the next strobe or write
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [35:0] exp);
      i_sswo_bus_master.op(1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 36'h0);
      look();
      chk(dataOut, exp);
      chk(dataOe, '1);
   endtask
   task automatic t_lanes();
      logic [35:0] exp;
      for (int m = 0; m < 16; m++) begin
         i_sswo_bus_master.op(1'b1, 1'b0, 1'b0, 1'b1, 4'hf, BASE);
         look();
         chk(writeCycle, 1'b1);
         chk(dataOe, '0);
         i_sswo_bus_master.op(1'b1, 1'b0, 1'b1, 1'b0, ~m[3:0], NEWD);
         look();
         chk(writeCycle, m != 0);
         exp = BASE;
         for (int k = 0; k < 4; k++) if (m[k]) exp[9*k+:9] = NEWD[9*k+:9];
         rd(exp);
      end
   endtask
   task automatic t_proc();
      i_sswo_bus_master.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, ~NEWD);
      look();
      chk(writeCycle, 1'b0);
      rd(NEWD);
      // enable is unclocked, so change it well away from any edge
      i_sswo_bus_master.set_oe(1'b1);
      #1 chk(dataOe, '0);
      i_sswo_bus_master.set_oe(1'b0);
      #1 chk(dataOe, '1);
      i_sswo_bus_master.deselect();
      look();
      chk(dataOe, '0);
      chk(writeCycle, 1'b0);
   endtask
   task automatic final_report();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge sys_clk);
      t_lanes();
      t_proc();
      final_report();
   end
endmodule
bind sswo_top sswo_properties i_sswo_properties (.*);
`default_nettype wire
